/* pkg/stc_map.svh */
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define STC_ADDR_CTRL    4'h0
`define STC_ADDR_CNT_LO  4'h1
`define STC_ADDR_CNT_HI  4'h2
`define STC_ADDR_FLAG    4'h3
`define STC_ADDR_IRQEN   4'h4

// ----------------------------------------------------------------
// control, flag and enable bit positions
// ----------------------------------------------------------------
`define STC_BIT_ON       0
`define STC_BIT_CS       1
`define STC_BIT_SYNCD    2
`define STC_BIT_OSC      3
`define STC_BIT_PS_LO    4
`define STC_BIT_PS_HI    5
`define STC_CTRL_W       6
`define STC_BIT_OVF      0
`define STC_BIT_IRQEN    0

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define STC_CTRL_RST     6'h00
`define STC_CNT_ZERO     16'h0000
`define STC_CNT_MAX      16'hffff
`define STC_DIV_LAST     2'h3
`define STC_PINS_IN      2'h3
`define STC_PINS_ZERO    2'h0
`define STC_BYTE_ZERO    8'h00

`endif

/* pkg/stc_pkg.sv */
`include "stc_map.svh"

package stc_pkg;

    typedef struct packed {
        logic [`STC_CTRL_W-1:0] ctrl;
        logic [15:0]            cnt;
        logic                   ovf;
        logic                   irq_en;
        logic [1:0]             div;
        logic                   sy1;
        logic                   sy2;
        logic                   sy3;
        logic                   raw_prev;
        logic [7:0]             rdata;
        logic                   irq;
        logic [1:0]             pin_dir;
        logic [1:0]             pin_rd;
    } stc_state_type;

    typedef struct packed {
        logic [2:0] cnt;
    } stc_ps_state_type;

endpackage

/* design/stc_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module stc_prescaler
    import stc_pkg::*;
#(
    parameter int SEL_W = 2,
    parameter int CNT_W = 3
)(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             clr_i,
    input  wire logic             tick_i,
    input  wire logic [SEL_W-1:0] sel_i,
    output logic                  tick_o
);

    stc_ps_state_type state_ff;
    stc_ps_state_type nxt_state;
    logic [CNT_W-1:0] mask;

    // ----------------------------------------------------------------
    // divide by 1, 2, 4 or 8
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        mask = CNT_W'((1 << sel_i) - 1);
        tick_o = tick_i && ((state_ff.cnt & mask) == mask);
        if (clr_i)
        begin
            nxt_state.cnt = '0;
        end
        else if (tick_i)
        begin
            nxt_state.cnt = state_ff.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

endmodule // stc_prescaler

`default_nettype wire

/* design/stc_timer.sv */
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

// How it works
// - the count is a high byte and a low byte, both readable and writable.
// - the count runs up from zero to all ones and wraps back to zero.
// - each wrap sets a sticky overflow flag that only software clears.
// - the interrupt output follows the flag only while its enable bit is set.
// - control bit 1 picks timer mode or counter mode.
// - timer mode counts the internal clock, one tick every four clocks.
// - counter mode counts rising edges of the external clock pin.
// - the count advances only while control bit 0 is set.
// - a reset input from the compare module clears the count.
// - with the oscillator on both pins are inputs and their port bits read 0.
// - a two-bit field selects division by 1, 2, 4 or 8.
// - in counter mode the pin is synchronised unless the sync-disable bit is set.
// - in timer mode the sync-disable bit has no effect.
// - the top two control bits read 0 and drop writes; the rest reset to 0.
// - the oscillator enable bit turns the dedicated oscillator on or off.
module stc_timer
    import stc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       ext_clk_i,
    input  wire logic       ccp_reset_i,
    input  wire logic [1:0] port_dir_i,
    input  wire logic [1:0] pin_in_i,
    output logic [7:0]      rdata_o,
    output logic            irq_o,
    output logic            osc_en_o,
    output logic [1:0]      pin_dir_o,
    output logic [1:0]      pin_rd_o
);

    stc_state_type state_ff;
    stc_state_type nxt_state;
    logic          wr_ctrl;
    logic          wr_lo;
    logic          wr_hi;
    logic          wr_flag;
    logic          wr_irqen;
    logic          cnt_wr;
    logic          tick_int;
    logic          edge_sync;
    logic          edge_raw;
    logic          tick_ext;
    logic          tick_sel;
    logic          tick_ps;
    logic          inc;
    logic          wrap;
    logic          timer_on;
    logic          mode_ext;
    logic          sync_dis;
    logic [1:0]    ps_sel;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign wr_ctrl  = wr_i && (addr_i == `STC_ADDR_CTRL);
    assign wr_lo    = wr_i && (addr_i == `STC_ADDR_CNT_LO);
    assign wr_hi    = wr_i && (addr_i == `STC_ADDR_CNT_HI);
    assign wr_flag  = wr_i && (addr_i == `STC_ADDR_FLAG);
    assign wr_irqen = wr_i && (addr_i == `STC_ADDR_IRQEN);
    assign cnt_wr   = wr_lo || wr_hi;

    assign timer_on = state_ff.ctrl[`STC_BIT_ON];
    assign mode_ext = state_ff.ctrl[`STC_BIT_CS];
    assign sync_dis = state_ff.ctrl[`STC_BIT_SYNCD];
    assign ps_sel   = state_ff.ctrl[`STC_BIT_PS_HI:`STC_BIT_PS_LO];

    // ----------------------------------------------------------------
    // clock sources
    // ----------------------------------------------------------------
    // sy1 feeds only sy2; edges are seen on sy2 against sy3
    assign tick_int  = (state_ff.div == `STC_DIV_LAST);
    assign edge_sync = state_ff.sy2 && !state_ff.sy3;
    // unsynchronised path uses the live pin against raw_prev, so it is two clocks faster
    assign edge_raw  = ext_clk_i && !state_ff.raw_prev;
    assign tick_ext  = sync_dis ? edge_raw : edge_sync;
    // sync-disable only steers the external path
    assign tick_sel  = mode_ext ? tick_ext : tick_int;

    stc_prescaler #(
        .SEL_W (2),
        .CNT_W (3)
    ) u_prescaler (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .clr_i  (cnt_wr || !timer_on),
        .tick_i (tick_sel && timer_on),
        .sel_i  (ps_sel),
        .tick_o (tick_ps)
    );

    assign inc  = tick_ps && timer_on;
    assign wrap = inc && !cnt_wr && !ccp_reset_i
                  && (state_ff.cnt == `STC_CNT_MAX);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.div = state_ff.div + 2'h1;
        nxt_state.sy1 = ext_clk_i;
        nxt_state.sy2 = state_ff.sy1;
        nxt_state.sy3 = state_ff.sy2;
        nxt_state.raw_prev = ext_clk_i;

        if (wr_ctrl)
        begin
            nxt_state.ctrl = wdata_i[`STC_CTRL_W-1:0];
        end

        if (ccp_reset_i)
        begin
            nxt_state.cnt = `STC_CNT_ZERO;
        end
        else if (cnt_wr)
        begin
            if (wr_lo)
            begin
                nxt_state.cnt[7:0] = wdata_i;
            end
            if (wr_hi)
            begin
                nxt_state.cnt[15:8] = wdata_i;
            end
        end
        else if (inc)
        begin
            // all ones plus one folds to zero in 16 bits
            nxt_state.cnt = state_ff.cnt + 16'h0001;
        end

        // a wrap in the clearing cycle still lands
        if (wr_flag)
        begin
            nxt_state.ovf = wdata_i[`STC_BIT_OVF] || wrap;
        end
        else if (wrap)
        begin
            nxt_state.ovf = 1'h1;
        end

        if (wr_irqen)
        begin
            nxt_state.irq_en = wdata_i[`STC_BIT_IRQEN];
        end

        nxt_state.irq = nxt_state.ovf && nxt_state.irq_en;

        if (nxt_state.ctrl[`STC_BIT_OSC])
        begin
            nxt_state.pin_dir = `STC_PINS_IN;
            nxt_state.pin_rd  = `STC_PINS_ZERO;
        end
        else
        begin
            nxt_state.pin_dir = port_dir_i;
            nxt_state.pin_rd  = pin_in_i;
        end

        nxt_state.rdata = `STC_BYTE_ZERO;
        if (rd_i)
        begin
            case (addr_i)
                `STC_ADDR_CTRL:
                begin
                    nxt_state.rdata = {2'h0, state_ff.ctrl};
                end
                `STC_ADDR_CNT_LO:
                begin
                    nxt_state.rdata = state_ff.cnt[7:0];
                end
                `STC_ADDR_CNT_HI:
                begin
                    nxt_state.rdata = state_ff.cnt[15:8];
                end
                `STC_ADDR_FLAG:
                begin
                    nxt_state.rdata = {7'h00, state_ff.ovf};
                end
                `STC_ADDR_IRQEN:
                begin
                    nxt_state.rdata = {7'h00, state_ff.irq_en};
                end
                default:
                begin
                    nxt_state.rdata = `STC_BYTE_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign rdata_o   = state_ff.rdata;
    assign irq_o     = state_ff.irq;
    assign osc_en_o  = state_ff.ctrl[`STC_BIT_OSC];
    assign pin_dir_o = state_ff.pin_dir;
    assign pin_rd_o  = state_ff.pin_rd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_wrap_sets_flag: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        wrap |=> state_ff.ovf && (state_ff.cnt == `STC_CNT_ZERO)
    ) else $error("wrap did not set flag and zero count");

    a_flag_sticky: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        state_ff.ovf && !wr_flag |=> state_ff.ovf
    ) else $error("overflow flag dropped without a clear");

    a_irq_gated: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (wr_irqen && !wdata_i[`STC_BIT_IRQEN]) |=> !irq_o && !state_ff.irq_en
    ) else $error("interrupt not blocked by enable");

    a_irq_follows: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        state_ff.ovf && state_ff.irq_en && !wr_flag && !wr_irqen |=> irq_o
    ) else $error("enabled flag not forwarded");

    a_stop_holds: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !timer_on && !cnt_wr && !ccp_reset_i |=> $stable(state_ff.cnt)
    ) else $error("count moved while stopped");

    a_ccp_clears: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ccp_reset_i |=> state_ff.cnt == `STC_CNT_ZERO
    ) else $error("compare reset did not clear count");

    a_ctrl_top_zero: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        rd_i && (addr_i == `STC_ADDR_CTRL) |=> rdata_o[7:`STC_CTRL_W] == 2'h0
    ) else $error("unimplemented control bits read nonzero");

    a_osc_pins_in: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        state_ff.ctrl[`STC_BIT_OSC] && !wr_ctrl
        |=> pin_dir_o == `STC_PINS_IN && pin_rd_o == `STC_PINS_ZERO
    ) else $error("pins not forced to input under oscillator");

    a_int_spacing: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        tick_int |=> !tick_int [*3] ##1 tick_int
    ) else $error("internal tick not one in four clocks");

    a_timer_ignores_sync: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !mode_ext && timer_on && (ps_sel == 2'h0) && !cnt_wr && !ccp_reset_i
        |-> inc == tick_int
    ) else $error("timer mode not counting internal clock");

    // a pin rise takes two clocks to reach the synchronised edge
    a_sync_pin_edge: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        mode_ext && !sync_dis && timer_on && (ps_sel == 2'h0) && !cnt_wr && !ccp_reset_i
        && $past(ext_clk_i, 2) && !$past(ext_clk_i, 3) |-> inc
    ) else $error("synchronised pin rise not counted");

    a_raw_pin_edge: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        mode_ext && sync_dis && timer_on && (ps_sel == 2'h0) && !cnt_wr && !ccp_reset_i
        && ext_clk_i && !$past(ext_clk_i) |-> inc
    ) else $error("unsynchronised pin rise not counted");

    a_no_pin_edge: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        mode_ext && sync_dis && !(ext_clk_i && !$past(ext_clk_i)) |-> !inc
    ) else $error("count moved without a pin rise");

    a_osc_output: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        wr_ctrl |=> osc_en_o == $past(wdata_i[`STC_BIT_OSC])
    ) else $error("oscillator enable not following control");

    // ----------------------------------------------------------------
    // count, control, flag, interrupt and pin checks
    // ----------------------------------------------------------------
    a_count_step: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        inc && !cnt_wr && !ccp_reset_i |=> state_ff.cnt == $past(state_ff.cnt) + 16'h0001
    ) else $error("count did not step by one");

    a_low_byte_write: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        wr_lo && !ccp_reset_i |=> state_ff.cnt[7:0] == $past(wdata_i)
    ) else $error("low byte write lost");

    a_high_byte_write: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        wr_hi && !ccp_reset_i |=> state_ff.cnt[15:8] == $past(wdata_i)
    ) else $error("high byte write lost");

    a_ctrl_write: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        wr_ctrl |=> state_ff.ctrl == $past(wdata_i[`STC_CTRL_W-1:0])
    ) else $error("control write not held");

    a_flag_clears: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        wr_flag && !wdata_i[`STC_BIT_OVF] && !wrap |=> !state_ff.ovf
    ) else $error("overflow flag not cleared");

    a_no_false_flag: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !state_ff.ovf && !wrap && !wr_flag |=> !state_ff.ovf
    ) else $error("overflow flag set without a wrap");

    a_irq_blocked: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !state_ff.irq_en && !wr_irqen |=> !irq_o
    ) else $error("interrupt raised while disabled");

    a_pins_follow_port: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !state_ff.ctrl[`STC_BIT_OSC] && !wr_ctrl
        |=> pin_dir_o == $past(port_dir_i) && pin_rd_o == $past(pin_in_i)
    ) else $error("pins not following port with oscillator off");

endmodule // stc_timer

`default_nettype wire

/* tb/stc_ext_src.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// clock source on the external count pin
// ----------------------------------------------------------------
module stc_ext_src (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [7:0] n_i,
    input  wire logic [3:0] half_i,
    output logic            pin_o,
    output logic            busy_o
);
    int   left = 0;
    int   ph   = 0;
    logic lvl  = 1'h0;

    assign pin_o  = lvl;
    assign busy_o = (left != 0);

    // low between bursts; each phase several clocks so the synchroniser sees it
    always @(posedge clk_i)
    begin
        if (start_i)
        begin
            left <= 2 * n_i;
            ph   <= half_i;
        end
        else if (left != 0)
        begin
            if (ph > 1)
                ph <= ph - 1;
            else
            begin
                lvl   <= ~lvl;
                left  <= left - 1;
                ph    <= half_i;
            end
        end
    end
endmodule // stc_ext_src

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

module tb_top;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        ext_clk;
    logic        ccp_reset_i = 1'b0;
    logic [1:0]  port_dir_i = 2'h1;
    logic [1:0]  pin_in_i = 2'h2;
    logic [7:0]  rdata_o;
    logic        irq_o;
    logic        osc_en_o;
    logic [1:0]  pin_dir_o;
    logic [1:0]  pin_rd_o;
    logic        src_start = 1'b0;
    logic        src_busy;
    logic [7:0]  rv;
    logic [15:0] cnt;
    logic [15:0] c2;
    logic [15:0] ex;
    int          n_mismatch = 0;
    int          tests_run = 0;

    always #2.5 clk_i = ~clk_i;

    stc_timer u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .ext_clk_i(ext_clk), .ccp_reset_i(ccp_reset_i),
        .port_dir_i(port_dir_i), .pin_in_i(pin_in_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .osc_en_o(osc_en_o), .pin_dir_o(pin_dir_o), .pin_rd_o(pin_rd_o)
    );

    stc_ext_src u_src (
        .clk_i(clk_i), .start_i(src_start), .n_i(8'h00 + rv), .half_i(4'h4),
        .pin_o(ext_clk), .busy_o(src_busy)
    );

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rd_cnt(output logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(`STC_ADDR_CNT_LO, lo);
        rd(`STC_ADDR_CNT_HI, hi);
        c = {hi, lo};
    endtask

    task automatic clr_cnt;
        wr(`STC_ADDR_CNT_LO, 8'h00);
        wr(`STC_ADDR_CNT_HI, 8'h00);
    endtask

    // rv carries the edge count to the source
    task automatic pulse(input logic [7:0] n);
        rv = n;
        @(posedge clk_i);
        src_start <= 1'b1;
        @(posedge clk_i);
        src_start <= 1'b0;
        // busy rises on the same edge that takes start, so poll one edge later
        @(posedge clk_i);
        for (int i = 0; i < 200 && src_busy === 1'b1; i++)
            @(posedge clk_i);
        repeat (8) @(posedge clk_i);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs;
        for (int a = 0; a < 5; a++)
        begin
            rd(a[3:0], rv);
            chk("reg_reset", {8'h00, rv}, 16'h0000);
        end
        wr(`STC_ADDR_CTRL, 8'hff);
        rd(`STC_ADDR_CTRL, rv);
        chk("ctrl_top_bits", {8'h00, rv}, 16'h003f);
        wr(4'h9, 8'h5a);
        rd(4'h9, rv);
        chk("unmapped", {8'h00, rv}, 16'h0000);
        wr(`STC_ADDR_CTRL, 8'h00);
    endtask

    task automatic t_pins;
        wr(`STC_ADDR_CTRL, 8'h08);
        @(posedge clk_i);
        #1;
        chk("osc_on", {15'h0, osc_en_o}, 16'h0001);
        chk("pin_dir_osc", {14'h0, pin_dir_o}, 16'h0003);
        chk("pin_rd_osc", {14'h0, pin_rd_o}, 16'h0000);
        wr(`STC_ADDR_CTRL, 8'h00);
        @(posedge clk_i);
        #1;
        chk("osc_off", {15'h0, osc_en_o}, 16'h0000);
        chk("pin_dir_port", {14'h0, pin_dir_o}, 16'h0001);
        chk("pin_rd_port", {14'h0, pin_rd_o}, 16'h0002);
    endtask

    // odd codes also set the sync-disable bit, which timer mode must ignore
    task automatic t_rate;
        for (int p = 0; p < 4; p++)
        begin
            clr_cnt();
            wr(`STC_ADDR_CTRL, {2'h0, p[1:0], 1'h0, p[0], 2'h1});
            repeat (127) @(posedge clk_i);
            wr(`STC_ADDR_CTRL, 8'h00);
            rd_cnt(cnt);
            ex = 16'd32 >> p;
            chk("rate", {15'h0, cnt + 16'h1 >= ex && cnt <= ex + 16'h1}, 16'h1);
            repeat (20) @(posedge clk_i);
            rd_cnt(c2);
            chk("stopped", c2, cnt);
        end
    endtask

    task automatic t_wrap;
        wr(`STC_ADDR_CNT_LO, 8'hfe);
        wr(`STC_ADDR_CNT_HI, 8'hff);
        wr(`STC_ADDR_CTRL, 8'h01);
        repeat (16) @(posedge clk_i);
        wr(`STC_ADDR_CTRL, 8'h00);
        rd_cnt(cnt);
        chk("wrap", {15'h0, cnt >= 16'h0001 && cnt <= 16'h0004}, 16'h1);
        repeat (10) @(posedge clk_i);
        rd(`STC_ADDR_FLAG, rv);
        chk("flag_sticky", {8'h00, rv}, 16'h0001);
        chk("irq_masked", {15'h0, irq_o}, 16'h0000);
        wr(`STC_ADDR_IRQEN, 8'h01);
        @(posedge clk_i);
        #1;
        chk("irq_enabled", {15'h0, irq_o}, 16'h0001);
        wr(`STC_ADDR_FLAG, 8'h00);
        @(posedge clk_i);
        #1;
        chk("irq_cleared", {15'h0, irq_o}, 16'h0000);
        rd(`STC_ADDR_FLAG, rv);
        chk("flag_cleared", {8'h00, rv}, 16'h0000);
        wr(`STC_ADDR_IRQEN, 8'h00);
    endtask

    task automatic t_counter;
        clr_cnt();
        wr(`STC_ADDR_CTRL, 8'h03);
        pulse(8'd5);
        rd_cnt(cnt);
        chk("edges_sync", cnt, 16'd5);
        wr(`STC_ADDR_CTRL, 8'h07);
        pulse(8'd5);
        rd_cnt(cnt);
        chk("edges_unsync", cnt, 16'd10);
        wr(`STC_ADDR_CTRL, 8'h13);
        pulse(8'd6);
        rd_cnt(cnt);
        chk("edges_div2", cnt, 16'd13);
        repeat (40) @(posedge clk_i);
        rd_cnt(cnt);
        chk("pin_idle", cnt, 16'd13);
        wr(`STC_ADDR_CTRL, 8'h00);
    endtask

    // compare reset wins over a byte write as well as the increment
    task automatic t_ccp;
        wr(`STC_ADDR_CTRL, 8'h01);
        repeat (40) @(posedge clk_i);
        ccp_reset_i <= 1'b1;
        wr(`STC_ADDR_CNT_LO, 8'h55);
        rd_cnt(cnt);
        chk("ccp_clear", cnt, 16'h0000);
        @(posedge clk_i);
        ccp_reset_i <= 1'b0;
        wr(`STC_ADDR_CTRL, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic wrap_up;
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_regs();
        t_pins();
        t_rate();
        t_wrap();
        t_counter();
        t_ccp();
        wrap_up();
    end

    initial
    begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
